// file: include/pmc_pkg.sv
/*
 holds the register map, field layout, mode and policy encodings and bundled output type
 of the operating-mode controller. assumes a single 200 MHz pclk domain and an apb master.
*/
package pmc_pkg;

   localparam logic [7:0] policy_offset = 8'h00;
   localparam logic [7:0] status_offset = 8'h04;
   localparam logic [7:0] config_offset = 8'h08;

   localparam int policy_level_lsb = 0;
   localparam int policy_sub_lsb = 4;
   localparam int config_reduced_bit = 0;

   localparam logic [2:0] policy_level_reset = 3'h0;
   localparam logic [1:0] policy_sub_reset = 2'h0;
   localparam logic config_reduced_reset = 1'b0;

   // debounce of pin-match wake: hold time in ns and derived cycles
   localparam int clk_period_ps = 5000;
   localparam int wake_hold_ns = 20;
   localparam int wake_hold_cycles = (wake_hold_ns * 1000 + clk_period_ps - 1) / clk_period_ps;

   localparam int num_fast_req = 6;

   // gray along run -> sleep -> stop -> standby -> shutdown
   typedef enum logic [2:0] {
      mode_run = 3'h0,
      mode_sleep = 3'h1,
      mode_stop = 3'h3,
      mode_standby = 3'h2,
      mode_shutdown = 3'h6
   } mode_t;

   typedef enum logic [1:0] {
      bus_clk_full = 2'h0,
      bus_clk_4mhz = 2'h1,
      bus_clk_32khz = 2'h2,
      bus_clk_off = 2'h3
   } bus_clk_t;

   typedef struct packed {
      logic core_clock_en;
      logic main_clock_en;
      logic main_clock_from_slow;
      logic fast_internal_osc_en;
      logic fast_osc_gear_4mhz;
      logic slow_internal_osc_en;
      bus_clk_t low_power_bus_clock;
      logic low_speed_clocks_all;
      logic designated_general_timers_clk;
      logic high_speed_domain_pwr;
      logic low_speed_domain_pwr;
      logic core_regulator_en;
   } power_ctrl_t;

endpackage

// file: src/pmc_sync.sv
/*
 three-flop synchroniser with agreement filter for pins arriving from outside pclk.
 assumes the input is a plain level.
*/
`timescale 1ns/1ps
module pmc_sync #(
   parameter int width = 1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [width-1:0] async_in,
   output logic [width-1:0] sync_out
);
   logic [width-1:0] s1_reg;
   logic [width-1:0] s2_reg;
   logic [width-1:0] s3_reg;
   logic [width-1:0] out_next;

   // a bit changes only once the second and third stages agree
   assign out_next = (s2_reg & s3_reg) | (sync_out & (s2_reg | s3_reg));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
         sync_out <= '0;
      end else begin
         s1_reg <= async_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         sync_out <= out_next;
      end
   end
endmodule // pmc_sync

// file: src/pmc_apb_regs.sv
/*
 apb slave holding the power policy and variant registers and reading back the mode.
 assumes a standard apb master with 32-bit data; answers with zero wait states.
*/
`timescale 1ns/1ps
module pmc_apb_regs (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [2:0] mode_now,
   input wire logic [1:0] run_sub_now,
   output logic [2:0] policy_level,
   output logic [1:0] policy_sub,
   output logic reduced_variant
);
   logic [2:0] level_reg;
   logic [1:0] sub_reg;
   logic reduced_reg;
   logic [31:0] prdata_next;
   logic wr_en;
   logic hit_policy;
   logic hit_status;
   logic hit_config;
   logic mapped;
   logic policy_legal;
   logic [2:0] wr_level;
   logic [1:0] wr_sub;

   assign hit_policy = paddr == pmc_pkg::policy_offset;
   assign hit_status = paddr == pmc_pkg::status_offset;
   assign hit_config = paddr == pmc_pkg::config_offset;
   assign mapped = hit_policy | hit_status | hit_config;
   assign wr_en = psel & penable & pwrite & pstrb[0];
   assign wr_level = pwdata[pmc_pkg::policy_level_lsb +: 3];
   assign wr_sub = pwdata[pmc_pkg::policy_sub_lsb +: 2];

   // levels 0..4 only; sub 3 never; stop 1 missing on reduced variant
   assign policy_legal = (wr_level <= 3'h4) && (wr_sub != 2'h3)
      && !(wr_level == 3'h2 && wr_sub == 2'h1 && reduced_reg)
      && !((wr_level == 3'h3) && (wr_sub == 2'h2));

   assign pready = 1'b1;
   assign pslverr = psel & penable & (!mapped | (pwrite & hit_policy & !policy_legal)
      | (pwrite & hit_status));

   always_comb begin
      prdata_next = 32'h0000_0000;
      if (hit_policy) begin
         prdata_next[pmc_pkg::policy_level_lsb +: 3] = level_reg;
         prdata_next[pmc_pkg::policy_sub_lsb +: 2] = sub_reg;
      end else if (hit_status) begin
         prdata_next[2:0] = mode_now;
         prdata_next[5:4] = run_sub_now;
      end else if (hit_config) begin
         prdata_next[pmc_pkg::config_reduced_bit] = reduced_reg;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         level_reg <= pmc_pkg::policy_level_reset;
         sub_reg <= pmc_pkg::policy_sub_reset;
         reduced_reg <= pmc_pkg::config_reduced_reset;
         prdata <= 32'h0000_0000;
      end else begin
         if (wr_en && hit_policy && policy_legal) begin
            level_reg <= wr_level;
            sub_reg <= wr_sub;
         end
         if (wr_en && hit_config) begin
            reduced_reg <= pwdata[pmc_pkg::config_reduced_bit];
         end
         if (psel && !penable && !pwrite) begin
            prdata <= prdata_next;
         end
      end
   end

   assign policy_level = level_reg;
   assign policy_sub = sub_reg;
   assign reduced_variant = reduced_reg;
endmodule // pmc_apb_regs

// file: src/power_mode_controller.sv
/*
 operating-mode controller: steps run/sleep/stop/standby/shutdown and drives clock gates,
 oscillator enables and domain power. assumes power-on reset on presetn, a core that
 pulses wait_entry when it executes a wait instruction, and wake pins from outside pclk.
*/
`timescale 1ns/1ps
module power_mode_controller #(
   parameter int num_fast_req = pmc_pkg::num_fast_req,
   parameter int num_match_pins = 4
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic wait_entry,
   input wire logic periph_irq,
   input wire logic [num_fast_req-1:0] fast_clock_req,
   input wire logic external_reset_pin_n,
   input wire logic debug_wire_wake,
   input wire logic [num_match_pins-1:0] match_pins,
   input wire logic [num_match_pins-1:0] match_level,
   output pmc_pkg::power_ctrl_t power_ctrl,
   output logic [2:0] mode_out,
   output logic fast_clock_grant
);
   logic [2:0] policy_level;
   logic [1:0] policy_sub;
   logic reduced_variant;
   pmc_pkg::mode_t mode_reg;
   pmc_pkg::mode_t mode_next;
   logic [1:0] sub_reg;
   logic [1:0] sub_next;
   logic [1:0] run_sub_reg;
   logic [1:0] run_sub_next;
   logic [1:0] fast_from_run_reg;
   logic boost_reg;
   logic boost_next;
   logic [num_match_pins+1:0] async_pins;
   logic [num_match_pins+1:0] synced_pins;
   logic [num_fast_req-1:0] req_synced;
   logic reset_pin_wake;
   logic debug_wake;
   logic pin_match;
   logic match_hold_done;
   logic [7:0] match_cnt_reg;
   logic any_fast_req;
   logic shutdown_wake;
   logic [2:0] target_level;
   pmc_pkg::power_ctrl_t ctrl_next;

   localparam logic [7:0] match_hold = 8'(pmc_pkg::wake_hold_cycles);

   function automatic pmc_pkg::mode_t level_to_mode(input logic [2:0] lvl);
      case (lvl)
         3'h0: level_to_mode = pmc_pkg::mode_run;
         3'h1: level_to_mode = pmc_pkg::mode_sleep;
         3'h2: level_to_mode = pmc_pkg::mode_stop;
         3'h3: level_to_mode = pmc_pkg::mode_standby;
         3'h4: level_to_mode = pmc_pkg::mode_shutdown;
         default: level_to_mode = pmc_pkg::mode_run;
      endcase
   endfunction

   pmc_apb_regs regs (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .pstrb(pstrb),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .mode_now(mode_reg),
      .run_sub_now(run_sub_reg),
      .policy_level(policy_level),
      .policy_sub(policy_sub),
      .reduced_variant(reduced_variant)
   );

   // reset pin is active low; invert so the synchroniser resets to "no wake"
   assign async_pins = {~external_reset_pin_n, debug_wire_wake, match_pins ^ ~match_level};

   pmc_sync #(
      .width(num_match_pins + 2)
   ) pin_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in(async_pins),
      .sync_out(synced_pins)
   );

   // requests come from peripherals on other clocks, so they are synchronised too
   pmc_sync #(
      .width(num_fast_req)
   ) req_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in(fast_clock_req),
      .sync_out(req_synced)
   );

   assign reset_pin_wake = synced_pins[num_match_pins + 1];
   assign debug_wake = synced_pins[num_match_pins];
   assign pin_match = |synced_pins[num_match_pins-1:0];
   assign any_fast_req = |req_synced;
   assign match_hold_done = match_cnt_reg >= match_hold;
   assign shutdown_wake = reset_pin_wake | debug_wake | match_hold_done;
   assign target_level = policy_level;

   // policy 1 of stop silently falls back to stop 0 on the reduced variant
   always_comb begin
      mode_next = mode_reg;
      sub_next = sub_reg;
      run_sub_next = run_sub_reg;
      boost_next = 1'b0;
      case (mode_reg)
         pmc_pkg::mode_run: begin
            if (target_level == 3'h0) begin
               run_sub_next = policy_sub;
               sub_next = policy_sub;
            end
            if (wait_entry && target_level != 3'h0) begin
               mode_next = level_to_mode(target_level);
               sub_next = policy_sub;
               if (target_level == 3'h2 && policy_sub == 2'h1 && reduced_variant) begin
                  sub_next = 2'h0;
               end
            end
         end
         pmc_pkg::mode_sleep, pmc_pkg::mode_stop, pmc_pkg::mode_standby: begin
            // no boost on the wake edge, or a grant would outlive the low mode
            boost_next = any_fast_req && mode_reg != pmc_pkg::mode_sleep && !periph_irq;
            if (periph_irq) begin
               mode_next = pmc_pkg::mode_run;
               sub_next = run_sub_reg;
            end
         end
         pmc_pkg::mode_shutdown: begin
            if (shutdown_wake) begin
               mode_next = pmc_pkg::mode_run;
               run_sub_next = 2'h0;
               sub_next = 2'h0;
            end
         end
         default: begin
            mode_next = pmc_pkg::mode_run;
            sub_next = 2'h0;
         end
      endcase
   end

   // output decode per mode and policy
   always_comb begin
      ctrl_next = '0;
      ctrl_next.core_regulator_en = 1'b1;
      ctrl_next.slow_internal_osc_en = 1'b1;
      ctrl_next.low_speed_domain_pwr = 1'b1;
      ctrl_next.low_speed_clocks_all = 1'b1;
      ctrl_next.designated_general_timers_clk = 1'b1;
      ctrl_next.low_power_bus_clock = pmc_pkg::bus_clk_full;
      case (mode_reg)
         pmc_pkg::mode_run: begin
            ctrl_next.core_clock_en = 1'b1;
            ctrl_next.main_clock_en = 1'b1;
            ctrl_next.high_speed_domain_pwr = 1'b1;
            ctrl_next.main_clock_from_slow = sub_reg != 2'h0;
            ctrl_next.fast_internal_osc_en = sub_reg != 2'h2;
         end
         pmc_pkg::mode_sleep: begin
            ctrl_next.main_clock_en = 1'b1;
            ctrl_next.high_speed_domain_pwr = 1'b1;
            ctrl_next.main_clock_from_slow = sub_reg != 2'h0;
            ctrl_next.fast_internal_osc_en = sub_reg != 2'h2;
         end
         pmc_pkg::mode_stop: begin
            case (sub_reg)
               2'h0: begin
                  ctrl_next.low_power_bus_clock = pmc_pkg::bus_clk_4mhz;
                  ctrl_next.fast_internal_osc_en = fast_from_run_reg != 2'h2;
               end
               2'h1: begin
                  ctrl_next.low_power_bus_clock = pmc_pkg::bus_clk_4mhz;
                  ctrl_next.fast_internal_osc_en = 1'b1;
                  ctrl_next.fast_osc_gear_4mhz = 1'b1;
               end
               default: begin
                  ctrl_next.low_power_bus_clock = pmc_pkg::bus_clk_32khz;
               end
            endcase
            // a fast request lifts the bus clock back to full speed for service
            if (boost_reg) begin
               ctrl_next.fast_internal_osc_en = 1'b1;
               ctrl_next.low_power_bus_clock = pmc_pkg::bus_clk_full;
            end
         end
         pmc_pkg::mode_standby: begin
            ctrl_next.low_power_bus_clock = pmc_pkg::bus_clk_32khz;
            ctrl_next.low_speed_clocks_all = sub_reg == 2'h0;
            if (boost_reg) begin
               ctrl_next.fast_internal_osc_en = 1'b1;
               ctrl_next.low_power_bus_clock = pmc_pkg::bus_clk_4mhz;
               ctrl_next.low_speed_clocks_all = 1'b1;
            end
         end
         pmc_pkg::mode_shutdown: begin
            ctrl_next = '0;
            ctrl_next.low_power_bus_clock = pmc_pkg::bus_clk_off;
         end
         default: begin
            ctrl_next.core_clock_en = 1'b1;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_reg <= pmc_pkg::mode_run;
         sub_reg <= 2'h0;
         run_sub_reg <= 2'h0;
         fast_from_run_reg <= 2'h0;
         boost_reg <= 1'b0;
         match_cnt_reg <= 8'h00;
      end else begin
         mode_reg <= mode_next;
         sub_reg <= sub_next;
         run_sub_reg <= run_sub_next;
         boost_reg <= boost_next;
         if (mode_reg == pmc_pkg::mode_run) begin
            fast_from_run_reg <= sub_reg;
         end
         // pin match must hold a few cycles to count, so glitches cannot wake
         if (mode_reg == pmc_pkg::mode_shutdown && pin_match) begin
            if (!match_hold_done) begin
               match_cnt_reg <= match_cnt_reg + 8'h01;
            end
         end else begin
            match_cnt_reg <= 8'h00;
         end
      end
   end

   // registered outputs, one cycle behind the mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         power_ctrl <= '0;
         mode_out <= 3'h0;
         fast_clock_grant <= 1'b0;
      end else begin
         power_ctrl <= ctrl_next;
         mode_out <= mode_reg;
         fast_clock_grant <= boost_reg;
      end
   end
endmodule // power_mode_controller

// file: tb/core_periph_model.sv
/*
 behavioural core and peripheral side: wait pulses, interrupt and fast requests.
 assumes the bench calls its tasks and the same pclk as the controller.
*/
`timescale 1ns/1ps
module core_periph_model (
   input wire logic pclk,
   output logic wait_entry,
   output logic periph_irq,
   output logic [5:0] fast_clock_req
);
   initial begin
      wait_entry = 1'b0;
      periph_irq = 1'b0;
      fast_clock_req = 6'h00;
   end
   task automatic wfi();
      @(posedge pclk);
      wait_entry <= 1'b1;
      @(posedge pclk);
      wait_entry <= 1'b0;
   endtask
   task automatic irq(input int n);
      @(posedge pclk);
      periph_irq <= 1'b1;
      repeat (n) @(posedge pclk);
      periph_irq <= 1'b0;
   endtask
   // requests are levels, held until the service is done
   task automatic req(input int b, input logic on);
      @(posedge pclk);
      fast_clock_req[b] <= on;
   endtask
endmodule // core_periph_model

// file: tb/power_mode_controller_sva.sv
/*
 port checker of the mode controller.
 assumes it is bound onto power_mode_controller.
*/
`timescale 1ns/1ps
module power_mode_controller_sva #(
   parameter int num_fast_req = 6,
   parameter int num_match_pins = 4
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic wait_entry,
   input wire logic periph_irq,
   input wire logic [num_fast_req-1:0] fast_clock_req,
   input wire logic external_reset_pin_n,
   input wire logic debug_wire_wake,
   input wire logic [num_match_pins-1:0] match_pins,
   input wire logic [num_match_pins-1:0] match_level,
   input wire pmc_pkg::power_ctrl_t power_ctrl,
   input wire logic [2:0] mode_out,
   input wire logic fast_clock_grant
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire in_run = mode_out == pmc_pkg::mode_run;
   wire in_sleep = mode_out == pmc_pkg::mode_sleep;
   wire in_stop = mode_out == pmc_pkg::mode_stop;
   wire in_stby = mode_out == pmc_pkg::mode_standby;
   wire in_sd = mode_out == pmc_pkg::mode_shutdown;
   sequence s_wake;
      periph_irq && (in_sleep || in_stop || in_stby);
   endsequence
   sequence s_back;
      ##[1:2] in_run;
   endsequence
   property p_irq_wake; s_wake |-> s_back; endproperty
   a_irq_wake: assert property (p_irq_wake) else $error("no return to run");
   property p_core; power_ctrl.core_clock_en |-> in_run; endproperty
   a_core: assert property (p_core) else $error("core clock outside run");
   // outputs read all zero during reset and for the first edge after it
   property p_hs; $past(presetn) |-> power_ctrl.high_speed_domain_pwr == (in_run || in_sleep); endproperty
   a_hs: assert property (p_hs) else $error("high-speed power wrong");
   property p_ls; $past(presetn) |-> power_ctrl.low_speed_domain_pwr == !in_sd; endproperty
   a_ls: assert property (p_ls) else $error("low-speed power wrong");
   property p_sd;
      in_sd |-> !power_ctrl.core_regulator_en && !power_ctrl.main_clock_en && !power_ctrl.fast_internal_osc_en
         && !power_ctrl.slow_internal_osc_en && power_ctrl.low_power_bus_clock == pmc_pkg::bus_clk_off;
   endproperty
   a_sd: assert property (p_sd) else $error("clock or regulator in shutdown");
   property p_exit; ($past(mode_out) != pmc_pkg::mode_run) && (mode_out != $past(mode_out)) |-> in_run; endproperty
   a_exit: assert property (p_exit) else $error("low mode left to non-run");
   property p_entry;
      ($past(mode_out) == pmc_pkg::mode_run) && !in_run |-> $past(wait_entry, 2) || $past(wait_entry, 3)
         || $past(wait_entry, 4);
   endproperty
   a_entry: assert property (p_entry) else $error("low mode without wait");
   property p_grant; fast_clock_grant |-> in_stop || in_stby; endproperty
   a_grant: assert property (p_grant) else $error("grant outside stop or standby");
   property p_stop_bus;
      in_stop && !fast_clock_grant |-> power_ctrl.low_power_bus_clock inside {pmc_pkg::bus_clk_4mhz,
         pmc_pkg::bus_clk_32khz};
   endproperty
   a_stop_bus: assert property (p_stop_bus) else $error("stop bus clock uncapped");
   property p_stop2; in_stop && power_ctrl.low_power_bus_clock == pmc_pkg::bus_clk_32khz
      |-> !power_ctrl.fast_internal_osc_en; endproperty
   a_stop2: assert property (p_stop2) else $error("fast osc on in stop 2");
   property p_stby; in_stby && !fast_clock_grant |-> !power_ctrl.fast_internal_osc_en
      && power_ctrl.designated_general_timers_clk; endproperty
   a_stby: assert property (p_stby) else $error("standby clocks wrong");
endmodule // power_mode_controller_sva
bind power_mode_controller power_mode_controller_sva #(.num_fast_req(num_fast_req),
   .num_match_pins(num_match_pins)) u_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .wait_entry(wait_entry), .periph_irq(periph_irq), .fast_clock_req(fast_clock_req),
   .external_reset_pin_n(external_reset_pin_n), .debug_wire_wake(debug_wire_wake), .match_pins(match_pins),
   .match_level(match_level), .power_ctrl(power_ctrl), .mode_out(mode_out), .fast_clock_grant(fast_clock_grant));

// file: tb/power_mode_controller_bench.sv
/*
 self-checking bench of the mode controller over apb and the core model.
 assumes the checker is bound from its own file.
*/
`timescale 1ns/1ps
module power_mode_controller_bench;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic wait_entry, periph_irq, external_reset_pin_n, debug_wire_wake, fast_clock_grant;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd, seed;
   logic [3:0] pstrb, match_pins, match_level;
   logic [5:0] fast_clock_req;
   logic [2:0] mode_out;
   pmc_pkg::power_ctrl_t power_ctrl, ev, em;
   int n_mismatch, total_checks, cyc, rs;
   core_periph_model core (.pclk(pclk), .wait_entry(wait_entry), .periph_irq(periph_irq),
      .fast_clock_req(fast_clock_req));
   power_mode_controller dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .wait_entry(wait_entry), .periph_irq(periph_irq), .fast_clock_req(fast_clock_req),
      .external_reset_pin_n(external_reset_pin_n), .debug_wire_wake(debug_wire_wake), .match_pins(match_pins),
      .match_level(match_level), .power_ctrl(power_ctrl), .mode_out(mode_out), .fast_clock_grant(fast_clock_grant));
   initial pclk = 1'b0;
   always #2.5 pclk = ~pclk;
   task automatic end_sim();
      $display("mismatches %0d checks %0d", n_mismatch, total_checks);
      if (n_mismatch == 0 && total_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         end_sim();
      end
   end
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e) begin
         n_mismatch++;
         $display("Error at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // only fields the behaviour pins down are masked in
   function automatic void expect_pc(input int lv, input int sb, input int r);
      ev = '0;
      em = '0;
      if (lv == 4) begin
         em = '1;
         ev.low_power_bus_clock = pmc_pkg::bus_clk_off;
         return;
      end
      em.core_clock_en = 1'b1;
      ev.core_clock_en = lv == 0;
      em.high_speed_domain_pwr = 1'b1;
      ev.high_speed_domain_pwr = lv < 2;
      em.low_speed_domain_pwr = 1'b1;
      ev.low_speed_domain_pwr = 1'b1;
      em.core_regulator_en = 1'b1;
      ev.core_regulator_en = 1'b1;
      em.fast_internal_osc_en = 1'b1;
      ev.fast_internal_osc_en = lv < 2 ? sb != 2 : lv == 2 && (sb == 0 ? r != 2 : sb == 1);
      if (lv < 2) begin
         em.main_clock_from_slow = 1'b1;
         ev.main_clock_from_slow = sb != 0;
      end
      if (lv > 0) begin
         em.slow_internal_osc_en = 1'b1;
         ev.slow_internal_osc_en = 1'b1;
      end
      if (lv == 2) begin
         em.low_power_bus_clock = pmc_pkg::bus_clk_off;
         ev.low_power_bus_clock = sb == 2 ? pmc_pkg::bus_clk_32khz : pmc_pkg::bus_clk_4mhz;
         em.fast_osc_gear_4mhz = sb == 1;
         ev.fast_osc_gear_4mhz = sb == 1;
      end
      if (lv == 3) begin
         em.low_speed_clocks_all = 1'b1;
         ev.low_speed_clocks_all = sb == 0;
         em.designated_general_timers_clk = 1'b1;
         ev.designated_general_timers_clk = 1'b1;
      end
   endfunction
   function automatic logic [31:0] mcode(input int lv);
      pmc_pkg::mode_t m[5] = '{pmc_pkg::mode_run, pmc_pkg::mode_sleep, pmc_pkg::mode_stop,
         pmc_pkg::mode_standby, pmc_pkg::mode_shutdown};
      return 32'(m[lv]);
   endfunction
   task automatic enter(input int lv, input int sb, input int r);
      apb(1'b1, 8'h00, {26'h0, 2'(r), 4'h0});
      repeat (3) @(posedge pclk);
      expect_pc(0, r, 0);
      chk(32'(power_ctrl & em), 32'(ev));
      apb(1'b1, 8'h00, {26'h0, 2'(sb), 1'b0, 3'(lv)});
      core.wfi();
      repeat (4) @(posedge pclk);
      chk(32'(mode_out), mcode(lv));
      expect_pc(lv, sb, r);
      chk(32'(power_ctrl & em), 32'(ev));
   endtask
   task automatic wgrant(input logic v);
      int k;
      k = 0;
      while (fast_clock_grant !== v && k < 30) begin
         @(posedge pclk);
         k++;
      end
   endtask
   initial begin
      {psel, penable, pwrite, paddr, pwdata, debug_wire_wake} = '0;
      pstrb = 4'hf;
      external_reset_pin_n = 1'b1;
      seed = 32'hb1c8;
      match_level = 4'(xs());
      match_pins = ~match_level;
      presetn = 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, 32'h0);
      expect_pc(0, 0, 0);
      chk(32'(power_ctrl & em), 32'(ev));
      core.wfi();
      repeat (4) @(posedge pclk);
      chk(32'(mode_out), 32'h0);
      apb(1'b0, 8'h0c, 32'h0);
      chk(32'(er), 32'h1);
      apb(1'b1, 8'h00, 32'h5);
      chk(32'(er), 32'h1);
      for (int lv = 1; lv < 4; lv++) begin
         for (int sb = 0; sb < 3 - (lv == 3); sb++) begin
            rs = xs() % 3;
            enter(lv, sb, rs);
            core.irq(2);
            repeat (4) @(posedge pclk);
            chk(32'(mode_out), 32'h0);
            expect_pc(0, rs, 0);
            chk(32'(power_ctrl & em), 32'(ev));
            apb(1'b0, 8'h04, 32'h0);
            chk(32'(rd[5:4]), 32'(rs));
         end
      end
      apb(1'b1, 8'h08, 32'h1);
      apb(1'b1, 8'h00, 32'h12);
      chk(32'(er), 32'h1);
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, 32'h13);
      apb(1'b1, 8'h08, 32'h0);
      apb(1'b1, 8'h00, 32'h12);
      apb(1'b1, 8'h08, 32'h1);
      core.wfi();
      repeat (4) @(posedge pclk);
      chk(32'(mode_out), mcode(2));
      chk(32'(power_ctrl.fast_osc_gear_4mhz), 32'h0);
      core.irq(2);
      apb(1'b1, 8'h08, 32'h0);
      enter(2, 2, 2);
      for (int b = 0; b < 6; b++) begin
         core.req(b, 1'b1);
         wgrant(1'b1);
         chk(32'(fast_clock_grant), 32'h1);
         chk(32'(power_ctrl.fast_internal_osc_en), 32'h1);
         core.req(b, 1'b0);
         wgrant(1'b0);
         chk(32'(mode_out), mcode(2));
      end
      core.irq(2);
      for (int w = 0; w < 3; w++) begin
         enter(4, 0, xs() % 3);
         core.irq(2);
         repeat (6) @(posedge pclk);
         chk(32'(mode_out), mcode(4));
         if (w == 0) debug_wire_wake <= 1'b1;
         else if (w == 1) external_reset_pin_n <= 1'b0;
         else match_pins <= match_level;
         repeat (10) @(posedge pclk);
         debug_wire_wake <= 1'b0;
         external_reset_pin_n <= 1'b1;
         match_pins <= ~match_level;
         repeat (8) @(posedge pclk);
         expect_pc(0, 0, 0);
         chk(32'(mode_out), 32'h0);
         chk(32'(power_ctrl & em), 32'(ev));
      end
      end_sim();
   end
endmodule // power_mode_controller_bench
